// *** core/wake_filter_pkg.sv ***
package wake_filter_pkg;

  // Register indices; each register sits at byte address index * 4
  localparam logic [11:0] IDX_CONFIG  = 12'h4a0;
  localparam logic [11:0] IDX_STATUS  = 12'h4a1;
  localparam logic [11:0] IDX_ADDR_45 = 12'h4a2;
  localparam logic [11:0] IDX_ADDR_23 = 12'h4a3;
  localparam logic [11:0] IDX_ADDR_01 = 12'h4a4;
  localparam logic [11:0] IDX_PASS_01 = 12'h4a5;
  localparam logic [11:0] IDX_PASS_23 = 12'h4a6;
  localparam logic [11:0] IDX_PASS_45 = 12'h4a7;
  localparam logic [11:0] IDX_PAT_01  = 12'h4a8;

  // Field positions
  localparam int unsigned POS_LEVEL_CLR = 11;
  localparam int unsigned POS_WOL_EN    = 7;
  localparam int unsigned POS_INT_SRC   = 12;

  // Values after reset
  localparam logic [15:0] CONFIG_RESET  = 16'h1000;
  localparam logic [15:0] ADDR_01_RESET = 16'h1010;
  localparam logic [15:0] PAT_01_RESET  = 16'h0010;
  localparam logic [15:0] DATA_RESET    = 16'h0000;

  // Frame bytes
  localparam logic [7:0] SFD_STD  = 8'hd5;
  localparam logic [7:0] SFD_ALT  = 8'h5d;
  localparam logic [7:0] PREAMBLE = 8'h55;
  localparam logic [7:0] PRE_REV  = 8'haa;
  localparam logic [7:0] SYNC     = 8'hff;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [6:0] ADDR_REPS_BYTES = 7'h60;
  localparam logic [2:0] GROUP_LAST = 3'h5;

  // Wake pulse timing
  localparam int unsigned HCLK_PERIOD_NS = 4;
  localparam int unsigned WAKE_CLK_PERIOD_NS = 8;
  localparam int unsigned WAKE_CLK_CYCLES =
    (WAKE_CLK_PERIOD_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
  localparam int unsigned WAKE_BASE_TICKS = 8;

  typedef enum logic [1:0] {
    ORDER_NONE   = 2'b00,
    ORDER_BITREV = 2'b01,
    ORDER_NIBSWP = 2'b10,
    ORDER_NIBREV = 2'b11
  } order_t;

  typedef struct packed {
    order_t     order;
    logic       sfd_alt;
    logic       crc_gate;
    logic       level_clr;
    logic [1:0] pulse_sel;
    logic       level_mode;
    logic       wol_en;
    logic       bit_mask;
    logic       pw_en;
    logic [2:0] rsvd;
    logic       pattern_en;
    logic       magic_en;
  } config_t;

  typedef struct packed {
    logic       active;
    logic       strobe;
    logic [7:0] data;
    logic       done;
    logic       crc_bad;
  } rx_stream_t;

endpackage

// *** core/wake_on_lan_frame_filter.sv ***
`timescale 1ns/1ns
// Contract
// R1: Ordering field reorders each received byte four ways; resets to no change.
// R2: Delimiter bit picks 0x5D when set, 0xD5 when clear; resets to 0xD5.
// R3: With CRC gating set, bad-CRC frames give no magic or pattern indication.
// R4: Level mode holds wake output until software writes the self-clearing clear bit.
// R5: Pulse mode lasts 8, 16, 32 or 64 wake-clock cycles by field code.
// R6: Indication select set means level mode, clear means pulse; resets pulse.
// R7: Detection and wake indications only while enable bit is set; resets off. A running pulse or held level outlasts a disable.
// R8: With password enabled, a magic packet also needs the six-byte password.
// R9: Pattern enable raises wake on a frame matching the configured pattern.
// R10: Magic enable raises wake on a valid magic packet.
// R11: Source bit routes wake or polarity to interrupt bit 1; set on enable.
// R12: Delimiter error latches a status flag that clears on read.
// R13: Bad CRC latches a status flag that clears on read.
// R14: Wrong password in magic packet latches intrusion flag, clears on read.
// R15: Valid frame with configured pattern latches a flag, clears on read.
// R16: Valid magic packet latches a flag that clears on read.
// R17: Three registers hold destination address bytes, even byte in upper half.
// R18: Three registers hold password bytes, lower-numbered byte in bits 7:0.
// R19: First pattern register holds byte 0 low and byte 1 high.
// R20: Magic packet is six 0xFF then sixteen address copies, then password.
module wake_on_lan_frame_filter (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic                       hready,
  input  wire logic [31:0]                hwdata,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire wake_filter_pkg::rx_stream_t rx,
  input  wire logic                       polarity_int,
  output logic                            wake_out,
  output logic                            int_bit1
);

  typedef enum logic [1:0] {
    F_HUNT = 2'b00,
    F_BODY = 2'b01,
    F_DROP = 2'b10
  } frame_state_t;
  typedef enum logic [1:0] {
    M_SYNC = 2'b00,
    M_ADDR = 2'b01,
    M_PASS = 2'b10,
    M_DONE = 2'b11
  } magic_state_t;

  wake_filter_pkg::config_t cfg;
  logic [15:0]              data_regs [2:8];
  logic                     int_src;
  logic [4:0]               flags;
  logic                     wr_pend;
  logic [11:0]              wr_idx;
  logic                     addr_ok;
  logic                     mapped;
  logic                     rd_status;
  logic                     wr_now;
  logic                     level_clr_wr;
  logic [7:0]               ordered;
  logic [7:0]               sfd_byte;
  frame_state_t             fstate;
  magic_state_t             mstate;
  logic [2:0]               sync_cnt;
  logic [6:0]               idx;
  logic [2:0]               col;
  logic                     pw_bad;
  logic [1:0]               pat_pos;
  logic                     pat_ok;
  logic                     body_byte;
  logic                     frame_end;
  logic                     gated;
  logic                     magic_ok;
  logic                     set_sfd;
  logic                     set_crc;
  logic                     set_hack;
  logic                     set_pat;
  logic                     set_magic;
  logic                     wake_evt;
  logic                     wake_level;
  logic [7:0]               pulse_cnt;
  logic                     pulse_active;
  logic [7:0]               hi_len;
  logic [7:0]               cur_len;

  function automatic logic [7:0] reorder(input logic [7:0] b, input logic [1:0] mode);
    case (mode)
      wake_filter_pkg::ORDER_NONE:   reorder = b;
      wake_filter_pkg::ORDER_BITREV: reorder = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      wake_filter_pkg::ORDER_NIBSWP: reorder = {b[3:0], b[7:4]};
      default:                       reorder = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
    endcase
  endfunction
  // Address byte k: even bytes in upper half, bytes 0/1 in the last register
  function automatic logic [7:0] addr_byte(input logic [2:0] k);
    logic [15:0] w;
    w = data_regs[4 - int'(k[2:1])];
    addr_byte = k[0] ? w[7:0] : w[15:8];
  endfunction
  // Password byte k: lower-numbered byte in the low half
  function automatic logic [7:0] pw_byte(input logic [2:0] k);
    logic [15:0] w;
    w = data_regs[5 + int'(k[2:1])];
    pw_byte = k[0] ? w[15:8] : w[7:0];
  endfunction
  function automatic logic [7:0] pulse_cycles(input logic [1:0] sel);
    pulse_cycles = 8'((wake_filter_pkg::WAKE_BASE_TICKS << sel)
                      * wake_filter_pkg::WAKE_CLK_CYCLES);
  endfunction
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];
  assign mapped    = (haddr[31:14] == 18'h0_0000) && (haddr[1:0] == 2'b00)
                     && (haddr[13:2] >= wake_filter_pkg::IDX_CONFIG)
                     && (haddr[13:2] <= wake_filter_pkg::IDX_PAT_01);
  assign rd_status = addr_ok & ~hwrite & mapped
                     & (haddr[13:2] == wake_filter_pkg::IDX_STATUS);
  assign wr_now    = wr_pend;
  // R4 clear strobe
  assign level_clr_wr = wr_now & (wr_idx == wake_filter_pkg::IDX_CONFIG)
                        & hwdata[wake_filter_pkg::POS_LEVEL_CLR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 12'h000;
    end else begin
      wr_pend <= addr_ok & hwrite & mapped;
      wr_idx  <= haddr[13:2];
    end
  end
  // Read data captured at the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite) begin
      if (!mapped) begin
        hrdata <= 32'h0000_0000;
      end else if (haddr[13:2] == wake_filter_pkg::IDX_CONFIG) begin
        hrdata <= {16'h0000, cfg};
      end else if (haddr[13:2] == wake_filter_pkg::IDX_STATUS) begin
        hrdata <= {16'h0000, 3'b000, int_src, 4'h0, flags[4:2], 3'b000, flags[1:0]};
      end else begin
        hrdata <= {16'h0000, data_regs[int'(haddr[13:2] - wake_filter_pkg::IDX_CONFIG)]};
      end
    end
  end
  // R1 R2 R6 R7 control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= wake_filter_pkg::CONFIG_RESET;
    end else if (wr_now && wr_idx == wake_filter_pkg::IDX_CONFIG) begin
      cfg           <= hwdata[15:0];
      // R4 self clearing
      cfg.level_clr <= 1'b0;
    end
  end
  // R17 R18 R19 byte storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 2; i <= 8; i++) begin
        data_regs[i] <= wake_filter_pkg::DATA_RESET;
      end
      data_regs[4] <= wake_filter_pkg::ADDR_01_RESET;
      data_regs[8] <= wake_filter_pkg::PAT_01_RESET;
    end else if (wr_now && wr_idx >= wake_filter_pkg::IDX_ADDR_45) begin
      data_regs[int'(wr_idx - wake_filter_pkg::IDX_CONFIG)] <= hwdata[15:0];
    end
  end
  // R11 source select, forced to wake when enable rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_src <= 1'b0;
    end else if (wr_now && wr_idx == wake_filter_pkg::IDX_CONFIG
                 && hwdata[wake_filter_pkg::POS_WOL_EN] && !cfg.wol_en) begin
      int_src <= 1'b1;
    end else if (wr_now && wr_idx == wake_filter_pkg::IDX_STATUS) begin
      int_src <= hwdata[wake_filter_pkg::POS_INT_SRC];
    end
  end
  // R1 byte reordering
  assign ordered  = reorder(rx.data, cfg.order);
  // R2 delimiter choice
  assign sfd_byte = cfg.sfd_alt ? wake_filter_pkg::SFD_ALT : wake_filter_pkg::SFD_STD;
  // R7 detection only when enabled
  assign body_byte = cfg.wol_en & rx.strobe & (fstate == F_BODY);
  assign frame_end = cfg.wol_en & rx.done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fstate <= F_HUNT;
    end else if (!cfg.wol_en || rx.done) begin
      fstate <= F_HUNT;
    end else begin
      case (fstate)
        F_HUNT: begin
          if (rx.strobe && ordered == sfd_byte) begin
            fstate <= F_BODY;
          end else if (rx.strobe && ordered != wake_filter_pkg::PREAMBLE
                       && ordered != wake_filter_pkg::PRE_REV) begin
            fstate <= F_DROP;
          end
        end
        F_BODY:  fstate <= F_BODY;
        F_DROP:  fstate <= F_DROP;
        default: fstate <= F_HUNT;
      endcase
    end
  end

  // R12 delimiter error
  assign set_sfd = cfg.wol_en & ~rx.done & rx.strobe & (fstate == F_HUNT)
                   & (ordered != sfd_byte) & (ordered != wake_filter_pkg::PREAMBLE)
                   & (ordered != wake_filter_pkg::PRE_REV);

  // Pattern compare over the first two payload bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pat_pos <= 2'b00;
      pat_ok  <= 1'b1;
    end else if (fstate != F_BODY) begin
      pat_pos <= 2'b00;
      pat_ok  <= 1'b1;
    end else if (body_byte && pat_pos != 2'b10) begin
      // R19 byte 0 in the low half
      pat_ok  <= pat_ok & (ordered == (pat_pos[0] ? data_regs[8][15:8] : data_regs[8][7:0]));
      pat_pos <= pat_pos + 2'b01;
    end
  end

  // R20 magic packet search, restarts on any sync or address mismatch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mstate   <= M_SYNC;
      sync_cnt <= 3'h0;
      idx      <= 7'h00;
      col      <= 3'h0;
      pw_bad   <= 1'b0;
    end else if (fstate != F_BODY) begin
      mstate   <= M_SYNC;
      sync_cnt <= 3'h0;
      idx      <= 7'h00;
      col      <= 3'h0;
      pw_bad   <= 1'b0;
    end else if (body_byte) begin
      case (mstate)
        M_SYNC: begin
          if (sync_cnt == wake_filter_pkg::SYNC_LEN && ordered == addr_byte(3'h0)) begin
            mstate <= M_ADDR;
            idx    <= 7'h01;
            col    <= 3'h1;
          end else if (ordered == wake_filter_pkg::SYNC) begin
            sync_cnt <= (sync_cnt == wake_filter_pkg::SYNC_LEN) ? sync_cnt
                        : sync_cnt + 3'h1;
          end else begin
            sync_cnt <= 3'h0;
          end
        end
        M_ADDR: begin
          if (ordered != addr_byte(col)) begin
            mstate   <= M_SYNC;
            sync_cnt <= (ordered == wake_filter_pkg::SYNC) ? 3'h1 : 3'h0;
          end else if (idx == wake_filter_pkg::ADDR_REPS_BYTES - 7'h01) begin
            // R8 password follows when enabled
            mstate <= cfg.pw_en ? M_PASS : M_DONE;
            col    <= 3'h0;
          end else begin
            idx <= idx + 7'h01;
            col <= (col == wake_filter_pkg::GROUP_LAST) ? 3'h0 : col + 3'h1;
          end
        end
        M_PASS: begin
          // R8 password compare
          pw_bad <= pw_bad | (ordered != pw_byte(col));
          col    <= col + 3'h1;
          if (col == wake_filter_pkg::GROUP_LAST) begin
            mstate <= M_DONE;
          end
        end
        M_DONE:  mstate <= M_DONE;
        default: mstate <= M_SYNC;
      endcase
    end
  end

  // R3 gating of indications on bad CRC
  assign gated     = cfg.crc_gate & rx.crc_bad;
  assign magic_ok  = (mstate == M_DONE) & ~(cfg.pw_en & pw_bad);
  // R13 bad CRC
  assign set_crc   = frame_end & rx.crc_bad & (fstate != F_HUNT);
  // R14 intrusion
  assign set_hack  = frame_end & (fstate == F_BODY) & ~gated
                     & (mstate == M_DONE) & cfg.pw_en & pw_bad;
  // R15 pattern found
  assign set_pat   = frame_end & (fstate == F_BODY) & ~gated
                     & (pat_pos == 2'b10) & pat_ok;
  // R16 magic found
  assign set_magic = frame_end & (fstate == F_BODY) & ~gated & magic_ok;
  // R9 R10 wake causes
  assign wake_evt  = (set_magic & cfg.magic_en) | (set_pat & cfg.pattern_en);

  // R12 R13 R14 R15 R16 latched flags; a set beats the read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= 5'h00;
    end else begin
      flags <= (flags & {5{~rd_status}})
               | {set_sfd, set_crc, set_hack, set_pat, set_magic};
    end
  end

  // R4 level indication; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_level <= 1'b0;
    end else if (!cfg.level_mode) begin
      wake_level <= 1'b0;
    end else begin
      wake_level <= wake_evt | (wake_level & ~level_clr_wr);
    end
  end

  // R5 pulse length counter, retriggers on a new event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt <= 8'h00;
    end else if (cfg.level_mode) begin
      pulse_cnt <= 8'h00;
    end else if (wake_evt) begin
      pulse_cnt <= pulse_cycles(cfg.pulse_sel);
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  assign pulse_active = (pulse_cnt != 8'h00);
  // R6 mode select
  assign wake_out = cfg.level_mode ? wake_level : pulse_active;
  // R11 interrupt routing
  assign int_bit1 = int_src ? wake_out : polarity_int;

  // Helper for pulse length check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_len  <= 8'h00;
      cur_len <= 8'h00;
    end else if (wake_evt) begin
      hi_len  <= 8'h00;
      cur_len <= pulse_cycles(cfg.pulse_sel);
    end else if (pulse_active) begin
      hi_len <= hi_len + 8'h01;
    end
  end

  ordering_swap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    cfg.order == wake_filter_pkg::ORDER_NIBSWP |-> ordered == {rx.data[3:0], rx.data[7:4]})
    else $error("nibble exchange wrong");
  sfd_found_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    cfg.wol_en && !rx.done && fstate == F_HUNT && rx.strobe && ordered == sfd_byte
    |=> fstate == F_BODY)
    else $error("delimiter not accepted");
  crc_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    rx.done && rx.crc_bad && cfg.crc_gate |-> !set_magic && !set_pat && !wake_evt)
    else $error("bad CRC frame indicated");
  level_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    cfg.level_mode && wake_out && !level_clr_wr && !wr_now |=> wake_out)
    else $error("level dropped without clear");
  level_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    cfg.level_mode && level_clr_wr && !wake_evt && hwdata[8]
    |=> !wake_out ##1 cfg.level_clr == 1'b0)
    else $error("level clear failed");
  pulse_len_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    !cfg.level_mode && $fell(pulse_active) |-> hi_len == cur_len)
    else $error("wake pulse length wrong");
  // A frame ending just before the disable may still land its flags
  disabled_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    !cfg.wol_en && !$past(cfg.wol_en) && !$past(rd_status)
    |-> !wake_evt && flags == $past(flags))
    else $error("activity while disabled");
  src_auto_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    wr_now && wr_idx == wake_filter_pkg::IDX_CONFIG && hwdata[7] && !cfg.wol_en
    |=> int_src && cfg.wol_en)
    else $error("source not forced to wake");
  read_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R16
    rd_status && !set_magic |=> flags[0] == 1'b0)
    else $error("status not cleared by read");
  magic_wake_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    set_magic && cfg.magic_en && !cfg.level_mode |=> wake_out [*8])
    else $error("magic packet gave no wake");

endmodule // wake_on_lan_frame_filter

// *** test/rx_frame_source.sv ***
`timescale 1ns/1ns
module rx_frame_source (
  input  wire logic                   hclk,
  output wake_filter_pkg::rx_stream_t rx
);
  initial rx = '0;
  // Idle data shows the inverse, never a stale byte
  task automatic put(input logic [7:0] b, input int gap);
    @(posedge hclk);
    rx.active <= 1'b1;
    rx.strobe <= 1'b1;
    rx.data   <= b;
    repeat (gap) begin
      @(posedge hclk);
      rx.strobe <= 1'b0;
      rx.data   <= ~b;
    end
  endtask
  // Status only valid with done, so flip it after
  task automatic finish(input logic bad);
    @(posedge hclk);
    rx.strobe  <= 1'b0;
    rx.done    <= 1'b1;
    rx.crc_bad <= bad;
    @(posedge hclk);
    rx.done    <= 1'b0;
    rx.crc_bad <= ~bad;
    rx.active  <= 1'b0;
    rx.data    <= ~rx.data;
  endtask
endmodule // rx_frame_source

// *** test/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic                        hclk = 1'b0;
  logic                        hresetn;
  logic                        hsel;
  logic [31:0]                 haddr;
  logic [1:0]                  htrans;
  logic                        hwrite;
  logic [2:0]                  hsize;
  logic                        hready;
  logic [31:0]                 hwdata;
  logic [31:0]                 hrdata;
  logic                        hreadyout;
  logic                        hresp;
  logic                        polarity_int;
  logic                        wake_out;
  logic                        int_bit1;
  wake_filter_pkg::rx_stream_t rx;
  wake_filter_pkg::config_t    cf;
  int                          n_errors;
  int                          n_compared;
  int                          len;
  int                          p0;
  logic [15:0]                 rv [9];
  logic [31:0]                 rd;
  logic [7:0]                  pay [$];

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  wake_on_lan_frame_filter i_dut (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hready       (hready),
    .hwdata       (hwdata),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .rx           (rx),
    .polarity_int (polarity_int),
    .wake_out     (wake_out),
    .int_bit1     (int_bit1)
  );

  rx_frame_source i_src (
    .hclk (hclk),
    .rx   (rx)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Offset counts registers from the configuration register
  task automatic ahb(input logic w, input int off, input logic [15:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {18'h0, wake_filter_pkg::IDX_CONFIG + 12'(off), 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input int off, input logic [15:0] exp);
    ahb(1'b0, off, 16'h0000);
    check(what, rd, {16'h0000, exp});
    check({what, " response"}, hresp, 1'b0);
  endtask

  task automatic wcfg(input wake_filter_pkg::config_t c);
    cf = c;
    ahb(1'b1, 0, c);
  endtask

  function automatic logic [7:0] reord(input logic [1:0] m, input logic [7:0] x);
    case (m)
      2'b01: return {<<{x}};
      2'b10: return {x[3:0], x[7:4]};
      2'b11: return {x[4], x[5], x[6], x[7], x[0], x[1], x[2], x[3]};
      default: return x;
    endcase
  endfunction

  // Each reordering is its own inverse, so the wire carries reord of the byte
  task automatic frame(input logic [7:0] sfd, input logic bad, input int gap);
    repeat (7) i_src.put(reord(cf.order, wake_filter_pkg::PREAMBLE), gap);
    i_src.put(reord(cf.order, sfd), gap);
    foreach (pay[i]) i_src.put(reord(cf.order, pay[i]), gap);
    i_src.finish(bad);
    len = 0;
    // Sampled mid-cycle, and an unknown counts as high
    repeat (200) begin
      @(negedge hclk);
      if (wake_out !== 1'b0) len++;
    end
  endtask

  task automatic pattern_pay;
    pay = {rv[8][7:0], rv[8][15:8], 8'($urandom), 8'($urandom)};
  endtask

  // Lead byte differs from pattern byte 0, so no pattern hit
  task automatic magic_pay(input int pw);
    logic [15:0] r;
    pay = {~rv[8][7:0], 8'($urandom)};
    repeat (6) pay.push_back(8'hff);
    repeat (16) for (int k = 0; k < 6; k++) begin
      r = rv[4 - k / 2];
      pay.push_back(k[0] ? r[7:0] : r[15:8]);
    end
    if (pw > 0) for (int k = 0; k < 6; k++) begin
      r = rv[5 + k / 2];
      pay.push_back((k[0] ? r[15:8] : r[7:0]) ^ ((pw == 2 && k == 3) ? 8'h01 : 8'h00));
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    polarity_int = 1'b0;
    n_errors = 0;
    n_compared = 0;
    p0 = wake_filter_pkg::WAKE_CLK_CYCLES * wake_filter_pkg::WAKE_BASE_TICKS;
    cf = wake_filter_pkg::CONFIG_RESET;
    void'($urandom(30128));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("config reset", 0, 16'h1000);
    rchk("status reset", 1, 16'h0000);
    for (int i = 2; i < 9; i++) rchk("data reset", i, i == 4 ? 16'h1010 : i == 8 ? 16'h0010 : 16'h0000);
    rchk("unmapped", 9, 16'h0000);
    // Address bytes kept below 0x80 so none reads as sync
    for (int i = 2; i < 9; i++) begin
      rv[i] = 16'($urandom) & (i < 5 ? 16'h7f7f : 16'hffff);
      ahb(1'b1, i, rv[i]);
      rchk("data rw", i, rv[i]);
    end
    repeat (4) begin
      polarity_int <= 1'($urandom);
      @(posedge hclk);
      #1 check("int_bit1 polarity", int_bit1, polarity_int);
    end
    pattern_pay();
    frame(wake_filter_pkg::SFD_STD, 1'b0, 0);
    check("wake disabled", len, 0);
    rchk("status disabled", 1, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      cf = 16'h1083;
      cf.pulse_sel = 2'(s);
      cf.order = wake_filter_pkg::order_t'(s);
      wcfg(cf);
      pattern_pay();
      frame(wake_filter_pkg::SFD_STD, 1'b0, s);
      check("pulse length", len, p0 << s);
      rchk("status pattern", 1, 16'h1002);
      rchk("status cleared", 1, 16'h1000);
    end
    wcfg(16'h1083);
    frame(wake_filter_pkg::SFD_STD, 1'b1, 0);
    check("gated wake", len, 0);
    rchk("status gated", 1, 16'h1040);
    wcfg(16'h0083);
    frame(wake_filter_pkg::SFD_STD, 1'b1, 1);
    check("ungated wake", len, p0);
    rchk("status ungated", 1, 16'h1042);
    wcfg(16'h1083);
    magic_pay(0);
    frame(wake_filter_pkg::SFD_STD, 1'b0, 0);
    check("magic wake", len, p0);
    rchk("status magic", 1, 16'h1001);
    wcfg(16'h10a3);
    magic_pay(2);
    frame(wake_filter_pkg::SFD_STD, 1'b0, 0);
    check("bad password wake", len, 0);
    rchk("status intrusion", 1, 16'h1020);
    magic_pay(1);
    frame(wake_filter_pkg::SFD_STD, 1'b0, 2);
    check("password wake", len, p0);
    rchk("status password", 1, 16'h1001);
    wcfg(16'h3083);
    pattern_pay();
    frame(wake_filter_pkg::SFD_ALT, 1'b0, 0);
    rchk("status alt delimiter", 1, 16'h1002);
    frame(wake_filter_pkg::SFD_STD, 1'b0, 0);
    check("delimiter error wake", len, 0);
    rchk("status delimiter error", 1, 16'h1080);
    wcfg(16'h1183);
    frame(wake_filter_pkg::SFD_STD, 1'b0, 0);
    check("level held", len, 200);
    check("int_bit1 wake", int_bit1, 1'b1);
    ahb(1'b1, 0, 16'h1983);
    repeat (2) @(posedge hclk);
    #1 check("level cleared", wake_out, 1'b0);
    rchk("clear bit reads zero", 0, 16'h1183);
    polarity_int <= 1'b1;
    ahb(1'b1, 1, 16'h0000);
    rchk("source cleared", 1, 16'h0002);
    #1 check("int_bit1 routed back", int_bit1, 1'b1);
    tally_and_finish();
  end
endmodule // testbench
